// file: inc/eki_pkg.sv
/*
 external and keypad interrupt package: register offsets, reset values,
 field layout and the packed carriers shared by the design.
 assumes a byte-wide register port with one-cycle read latency.
*/
package eki_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned KEY_N = 8;

  // register offsets
  localparam logic [7:0] OFS_POLARITY = 8'h9C;
  localparam logic [7:0] OFS_ENABLE = 8'h9D;
  localparam logic [7:0] OFS_PENDING = 8'h9E;
  localparam logic [7:0] OFS_MODE = 8'h9F;
  localparam logic [7:0] OFS_EXT_CTRL = 8'hA0;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hA1;
  localparam logic [7:0] OFS_IRQ_MASK = 8'hA2;

  localparam logic [7:0] RST_BYTE = 8'h00;

  // ext control layout: [0] trigger_type_zero, [1] trigger_type_one,
  // [2] ext_request_flag zero, [3] ext_request_flag one (read only)
  localparam int unsigned EC_TT0 = 0;
  localparam int unsigned EC_TT1 = 1;
  localparam int unsigned EC_IE0 = 2;
  localparam int unsigned EC_IE1 = 3;

  // irq status layout: [0] ext zero, [1] ext one, [2] keypad
  localparam int unsigned IS_EXT0 = 0;
  localparam int unsigned IS_EXT1 = 1;
  localparam int unsigned IS_KEY = 2;
  localparam int unsigned IS_W = 3;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } eki_bus_req_t;

  typedef struct packed {
    logic [1:0] ext_req;
    logic key_req;
    logic wake;
  } eki_cpu_req_t;

endpackage

// file: rtl/eki_top.sv
/*
 external and keypad interrupt block: two dedicated request pins with
 level or falling-edge trigger, eight keypad pins with per-pin enable,
 mode and polarity, sticky flags, a masked level interrupt output.
 assumes pins are asynchronous, the cpu pulses an acknowledge when it
 enters a dedicated service routine, and software owns the registers.
*/
`timescale 1ns/1ps

module eki_top
  import eki_pkg::*;
#(
  parameter int unsigned KEYS = eki_pkg::KEY_N
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire eki_pkg::eki_bus_req_t bus_req,
  output logic [eki_pkg::DATA_W-1:0] rdata,
  input wire logic [1:0] ext_request_pin_n,
  input wire logic [KEYS-1:0] keypad_port,
  input wire logic [1:0] ext_service_ack,
  output eki_pkg::eki_cpu_req_t cpu_req,
  output logic irq
);
  import eki_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // synchronisers and sample history

  logic [1:0] ext_meta_ff;
  logic [1:0] ext_sync_ff;
  logic [1:0] ext_prev_ff;
  logic [KEYS-1:0] key_meta_ff;
  logic [KEYS-1:0] key_sync_ff;
  logic [KEYS-1:0] key_prev_ff;

  // two flops per pin before any logic; prev holds the earlier sample
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_meta_ff <= 2'h3;
      ext_sync_ff <= 2'h3;
      ext_prev_ff <= 2'h3;
    end else if (ce) begin
      ext_meta_ff <= ext_request_pin_n;
      ext_sync_ff <= ext_meta_ff;
      ext_prev_ff <= ext_sync_ff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_meta_ff <= '1; // keys rest pulled high, so no false edge after reset
      key_sync_ff <= '1;
      key_prev_ff <= '1;
    end else if (ce) begin
      key_meta_ff <= keypad_port;
      key_sync_ff <= key_meta_ff;
      key_prev_ff <= key_sync_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // registers

  logic [DATA_W-1:0] polarity_ff;
  logic [DATA_W-1:0] enable_ff;
  logic [DATA_W-1:0] pending_ff;
  logic [DATA_W-1:0] mode_ff;
  logic [1:0] trig_type_ff;
  logic [1:0] ext_flag_ff;
  logic [IS_W-1:0] irq_stat_ff;
  logic [IS_W-1:0] irq_mask_ff;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  logic wr_pol;
  logic wr_en;
  logic wr_pend;
  logic wr_mode;
  logic wr_ext;
  logic wr_stat;
  logic wr_mask;
  assign wr_pol = ce && bus_req.wr && hit(bus_req.addr, OFS_POLARITY);
  assign wr_en = ce && bus_req.wr && hit(bus_req.addr, OFS_ENABLE);
  assign wr_pend = ce && bus_req.wr && hit(bus_req.addr, OFS_PENDING);
  assign wr_mode = ce && bus_req.wr && hit(bus_req.addr, OFS_MODE);
  assign wr_ext = ce && bus_req.wr && hit(bus_req.addr, OFS_EXT_CTRL);
  assign wr_stat = ce && bus_req.wr && hit(bus_req.addr, OFS_IRQ_STAT);
  assign wr_mask = ce && bus_req.wr && hit(bus_req.addr, OFS_IRQ_MASK);

  // plain configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      polarity_ff <= RST_BYTE;
      enable_ff <= RST_BYTE;
      mode_ff <= RST_BYTE;
      trig_type_ff <= 2'h0;
      irq_mask_ff <= '0;
    end else begin
      if (wr_pol) polarity_ff <= bus_req.wdata;
      if (wr_en) enable_ff <= bus_req.wdata;
      if (wr_mode) mode_ff <= bus_req.wdata;
      if (wr_ext) trig_type_ff <= {bus_req.wdata[EC_TT1], bus_req.wdata[EC_TT0]};
      if (wr_mask) irq_mask_ff <= bus_req.wdata[IS_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // keypad detection

  logic [KEYS-1:0] key_level_hit;
  logic [KEYS-1:0] key_edge_hit;
  logic [KEYS-1:0] key_detect;

  // per pin: level needs both samples at the chosen level, edge needs a change
  // into the chosen level; all pins feed one shared request
  genvar gi;
  generate
    for (gi = 0; gi < KEYS; gi++) begin : g_key
      assign key_level_hit[gi] = (key_sync_ff[gi] == polarity_ff[gi]) &&
                                 (key_prev_ff[gi] == polarity_ff[gi]);
      assign key_edge_hit[gi] = (key_sync_ff[gi] == polarity_ff[gi]) &&
                                (key_prev_ff[gi] != polarity_ff[gi]);
      assign key_detect[gi] = enable_ff[gi] &&
                              (mode_ff[gi] ? key_edge_hit[gi] : key_level_hit[gi]);
    end
  endgenerate

  // flags: reads never touch them; write sets and clears bitwise, detection wins
  logic [DATA_W-1:0] nxt_pending;
  always_comb begin
    nxt_pending = pending_ff;
    if (wr_pend) nxt_pending = bus_req.wdata;
    nxt_pending = nxt_pending | key_detect;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_ff <= RST_BYTE;
    end else if (ce) begin
      pending_ff <= nxt_pending;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // dedicated external requests

  logic [1:0] ext_fall;
  logic [1:0] ext_req;
  assign ext_fall = ext_prev_ff & ~ext_sync_ff;

  // edge flags are sticky until the cpu enters the routine; in level mode the
  // flag just follows the pin so a held request repeats
  logic [1:0] nxt_ext_flag;
  always_comb begin
    nxt_ext_flag = ext_flag_ff;
    for (int i = 0; i < 2; i++) begin
      if (trig_type_ff[i]) begin
        if (ext_service_ack[i]) nxt_ext_flag[i] = 1'b0;
        if (ext_fall[i]) nxt_ext_flag[i] = 1'b1;
      end else begin
        nxt_ext_flag[i] = ~ext_sync_ff[i];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_flag_ff <= 2'h0;
    end else if (ce) begin
      ext_flag_ff <= nxt_ext_flag;
    end
  end
  assign ext_req = ext_flag_ff;

  ////////////////////////////////////////////////////////////////////
  // interrupt status, mask and cpu requests

  logic [IS_W-1:0] events;
  assign events = {|key_detect, ext_fall[1] & trig_type_ff[1] | ~ext_sync_ff[1] & ~trig_type_ff[1],
                   ext_fall[0] & trig_type_ff[0] | ~ext_sync_ff[0] & ~trig_type_ff[0]};

  // write-one-to-clear; a simultaneous event keeps its bit set
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_stat_ff <= '0;
    end else if (ce) begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_stat ? bus_req.wdata[IS_W-1:0] : '0)) | events;
    end
  end

  // outputs registered; wake comes from either dedicated flag or any keypad detection, not from a software-set flag, so even power-down exits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cpu_req <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      cpu_req.ext_req <= nxt_ext_flag;
      cpu_req.key_req <= |nxt_pending;
      cpu_req.wake <= (|nxt_ext_flag) | (|key_detect);
      irq <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read port, data valid in the cycle after the strobe only

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= RST_BYTE;
    end else if (ce) begin
      rdata <= RST_BYTE;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          OFS_POLARITY: rdata <= polarity_ff;
          OFS_ENABLE: rdata <= enable_ff;
          OFS_PENDING: rdata <= pending_ff;
          OFS_MODE: rdata <= mode_ff;
          OFS_EXT_CTRL: rdata <= {4'h0, ext_req[1], ext_req[0], trig_type_ff};
          OFS_IRQ_STAT: rdata <= {5'h00, irq_stat_ff};
          OFS_IRQ_MASK: rdata <= {5'h00, irq_mask_ff};
          default: rdata <= RST_BYTE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_fall(int i);
    ext_prev_ff[i] && !ext_sync_ff[i];
  endsequence

  property p_edge_set0;
    @(posedge clk) disable iff (rst) (ce && trig_type_ff[0]) and s_fall(0) |=> ext_flag_ff[0];
  endproperty
  a_edge_set0: assert property (p_edge_set0) else $error("edge flag zero not set");

  property p_level0;
    @(posedge clk) disable iff (rst) ce && !trig_type_ff[0] && !ext_sync_ff[0] |=> ext_flag_ff[0];
  endproperty
  a_level0: assert property (p_level0) else $error("level request zero missed");

  property p_ack_clear1;
    @(posedge clk) disable iff (rst)
      ce && trig_type_ff[1] && ext_service_ack[1] && !ext_fall[1] |=> !ext_flag_ff[1];
  endproperty
  a_ack_clear1: assert property (p_ack_clear1) else $error("edge flag one not cleared");

  property p_key_set;
    @(posedge clk) disable iff (rst) ce && key_detect[0] |=> pending_ff[0];
  endproperty
  a_key_set: assert property (p_key_set) else $error("key flag not set");

  property p_key_disabled;
    @(posedge clk) disable iff (rst) !enable_ff[1] |-> !key_detect[1];
  endproperty
  a_key_disabled: assert property (p_key_disabled) else $error("disabled pin detected");

  property p_read_keeps;
    @(posedge clk) disable iff (rst) ce && bus_req.rd && !wr_pend && pending_ff[2] |=> pending_ff[2];
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read cleared a flag");

  property p_sw_set;
    @(posedge clk) disable iff (rst) wr_pend && bus_req.wdata[3] |=> pending_ff[3];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("software set lost");

  property p_key_req;
    @(posedge clk) disable iff (rst) ce |=> (cpu_req.key_req == (|pending_ff));
  endproperty
  a_key_req: assert property (p_key_req) else $error("key request mismatch");

  property p_level_two;
    @(posedge clk) disable iff (rst) !mode_ff[4] && key_detect[4] |-> key_prev_ff[4] == key_sync_ff[4];
  endproperty
  a_level_two: assert property (p_level_two) else $error("level on one sample");

  // both dedicated pins, sampling chain, keypad decode, wake, interrupt output and register port
  property p_edge_set1;
    @(posedge clk) disable iff (rst) (ce && trig_type_ff[1]) and s_fall(1) |=> ext_flag_ff[1];
  endproperty
  a_edge_set1: assert property (p_edge_set1) else $error("edge flag one not set");

  property p_level1;
    @(posedge clk) disable iff (rst) ce && !trig_type_ff[1] && !ext_sync_ff[1] |=> ext_flag_ff[1];
  endproperty
  a_level1: assert property (p_level1) else $error("level request one missed");

  property p_level_follow0;
    @(posedge clk) disable iff (rst) ce && !trig_type_ff[0] && ext_sync_ff[0] |=> !ext_flag_ff[0];
  endproperty
  a_level_follow0: assert property (p_level_follow0) else $error("level request zero stuck");

  property p_ack_clear0;
    @(posedge clk) disable iff (rst)
      ce && trig_type_ff[0] && ext_service_ack[0] && !ext_fall[0] |=> !ext_flag_ff[0];
  endproperty
  a_ack_clear0: assert property (p_ack_clear0) else $error("edge flag zero not cleared");

  property p_ext_chain;
    @(posedge clk) disable iff (rst) ce |=> ext_prev_ff == $past(ext_sync_ff);
  endproperty
  a_ext_chain: assert property (p_ext_chain) else $error("request pin sample skipped");

  property p_key_chain;
    @(posedge clk) disable iff (rst) ce |=> key_prev_ff == $past(key_sync_ff);
  endproperty
  a_key_chain: assert property (p_key_chain) else $error("keypad sample skipped");

  property p_mode_level;
    @(posedge clk) disable iff (rst)
      enable_ff[2] && !mode_ff[2] && key_sync_ff[2] == polarity_ff[2] &&
      key_prev_ff[2] == polarity_ff[2] |-> key_detect[2];
  endproperty
  a_mode_level: assert property (p_mode_level) else $error("held level not detected");

  property p_polarity;
    @(posedge clk) disable iff (rst) key_detect[6] |-> key_sync_ff[6] == polarity_ff[6];
  endproperty
  a_polarity: assert property (p_polarity) else $error("detection against polarity");

  property p_edge_change;
    @(posedge clk) disable iff (rst) mode_ff[5] && key_detect[5] |-> key_prev_ff[5] != key_sync_ff[5];
  endproperty
  a_edge_change: assert property (p_edge_change) else $error("edge without change");

  property p_detect_wins;
    @(posedge clk) disable iff (rst) wr_pend && !bus_req.wdata[0] && key_detect[0] |=> pending_ff[0];
  endproperty
  a_detect_wins: assert property (p_detect_wins) else $error("clear beat detection");

  property p_sw_clear;
    @(posedge clk) disable iff (rst) wr_pend && !bus_req.wdata[7] && !key_detect[7] |=> !pending_ff[7];
  endproperty
  a_sw_clear: assert property (p_sw_clear) else $error("software clear lost");

  property p_ext_wake;
    @(posedge clk) disable iff (rst) ce && (|nxt_ext_flag) |=> cpu_req.wake;
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("request pin did not wake");

  property p_key_wake;
    @(posedge clk) disable iff (rst) ce && (|key_detect) |=> cpu_req.wake;
  endproperty
  a_key_wake: assert property (p_key_wake) else $error("keypad did not wake");

  property p_irq_level;
    @(posedge clk) disable iff (rst) ce |=> irq == (|$past(irq_stat_ff & irq_mask_ff));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt output mismatch");

  property p_rdata_idle;
    @(posedge clk) disable iff (rst) ce && !bus_req.rd |=> rdata == RST_BYTE;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

endmodule

// file: dv/eki_src_model.sv
/*
 far-side model: external request sources and a keypad matrix.
 assumes the bench asks for pin levels; the model keeps every new level
 for at least two clock cycles before it accepts the next request.
*/
`timescale 1ns/1ps

module eki_src_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] ext_want_n,
  input wire logic [7:0] key_want,
  output logic [1:0] ext_pin_n,
  output logic [7:0] key_pin
);
  logic [1:0] hold_ff;

  // a new level is only let through once the old one stood two cycles,
  // so the sampler can never miss a short pulse
  // a level request stays until the bench releases it after service
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_pin_n <= 2'h3; // idle high, no request
      key_pin <= 8'hFF; // keys open, pulled high
      hold_ff <= 2'h2;
    end else if (((ext_want_n != ext_pin_n) || (key_want != key_pin)) && (hold_ff == 2'h2)) begin
      ext_pin_n <= ext_want_n;
      key_pin <= key_want;
      hold_ff <= 2'h1;
    end else if (hold_ff != 2'h2) begin
      hold_ff <= hold_ff + 2'h1;
    end
  end
endmodule

// file: dv/testbench.sv
/*
 self-checking bench for the external and keypad interrupt block.
 assumes the register port has one-cycle read latency and that the
 source model delays pin changes by at most two cycles.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end

module testbench;
  import eki_pkg::*;
  typedef struct packed {logic [7:0] pol, mode, en, p0, p1, exp;} eki_row_t;
  // polarity, mode, enable, start pins, end pins, expected flags
  localparam eki_row_t ROWS [6] = '{
    '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h0F, 8'hF0}, '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h3C, 8'h3C},
    '{8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h5A, 8'hA5}, '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'hC3, 8'hC3},
    '{8'h00, 8'h00, 8'h0F, 8'hFF, 8'h00, 8'h0F}, '{8'hF0, 8'hFF, 8'hFF, 8'h0F, 8'hF0, 8'hFF}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  eki_bus_req_t bus_req = '0;
  logic [7:0] rdata, key_want = 8'hFF, key_pin, q;
  logic [1:0] ext_want_n = 2'h3, ext_pin_n, ext_service_ack = 2'h0;
  eki_cpu_req_t cpu_req;
  logic irq;
  int err_total = 0, checks = 0, cyc = 0;

  eki_top dut_u (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rdata(rdata),
    .ext_request_pin_n(ext_pin_n), .keypad_port(key_pin), .ext_service_ack(ext_service_ack),
    .cpu_req(cpu_req), .irq(irq));
  eki_src_model src_u (.clk(clk), .rst(rst), .ext_want_n(ext_want_n), .key_want(key_want),
    .ext_pin_n(ext_pin_n), .key_pin(key_pin));

  always #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // bench hangs are cut short well past the expected run length
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      summarize();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus_req.wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe: take it mid-cycle,
  // then return on an edge so later stimulus stays edge-aligned
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus_req.rd <= 1'b0;
    @(negedge clk);
    d = rdata;
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    idle(2);
    rst <= 1'b0;
    for (int a = 'h9C; a <= 'hA2; a++) begin
      rd(a[7:0], q);
      `CHK(q, RST_BYTE)
    end
    wr(8'h50, 8'hFF); // unmapped place, write must vanish
    rd(8'h50, q);
    `CHK(q, 8'h00)
    // table rows: park pins, configure, clear flags, then move pins
    foreach (ROWS[i]) begin
      wr(OFS_ENABLE, 8'h00);
      key_want <= ROWS[i].p0;
      idle(8);
      wr(OFS_POLARITY, ROWS[i].pol);
      wr(OFS_MODE, ROWS[i].mode);
      wr(OFS_ENABLE, ROWS[i].en);
      wr(OFS_PENDING, 8'h00);
      key_want <= ROWS[i].p1;
      idle(8);
      rd(OFS_PENDING, q);
      `CHK(q, ROWS[i].exp)
      `CHK(cpu_req.key_req, 1'b1)
    end
    // software sets, keeps and clears flags
    wr(OFS_ENABLE, 8'h00);
    wr(OFS_PENDING, 8'h89);
    rd(OFS_PENDING, q);
    `CHK(q, 8'h89)
    rd(OFS_PENDING, q);
    `CHK(q, 8'h89)
    wr(OFS_PENDING, 8'h01);
    rd(OFS_PENDING, q);
    `CHK(q, 8'h01)
    wr(OFS_PENDING, 8'h00);
    idle(2);
    `CHK(cpu_req.key_req, 1'b0)
    // a held low level on pin zero wakes, and outlives a clearing write
    key_want <= 8'hFE;
    wr(OFS_POLARITY, 8'h00);
    wr(OFS_MODE, 8'h00);
    wr(OFS_ENABLE, 8'h01);
    idle(8);
    `CHK(cpu_req.wake, 1'b1)
    wr(OFS_PENDING, 8'h00);
    rd(OFS_PENDING, q);
    `CHK(q, 8'h01)
    wr(OFS_ENABLE, 8'h00);
    key_want <= 8'hFF;
    wr(OFS_PENDING, 8'h00);
    // both dedicated pins, falling edge, each cleared on its own service entry
    wr(OFS_EXT_CTRL, 8'h03);
    ext_want_n <= 2'b00;
    idle(8);
    `CHK(cpu_req.ext_req, 2'b11)
    `CHK(cpu_req.wake, 1'b1)
    rd(OFS_EXT_CTRL, q);
    `CHK(q, 8'h0F)
    ext_service_ack <= 2'b01;
    @(posedge clk);
    ext_service_ack <= 2'b00;
    idle(2);
    `CHK(cpu_req.ext_req, 2'b10)
    ext_service_ack <= 2'b10;
    @(posedge clk);
    ext_service_ack <= 2'b00;
    idle(3);
    `CHK(cpu_req.ext_req, 2'b00)
    ext_want_n <= 2'b11;
    // dedicated pin one, low level follows the pin
    wr(OFS_EXT_CTRL, 8'h00);
    ext_want_n <= 2'b01;
    idle(8);
    `CHK(cpu_req.ext_req, 2'b10)
    ext_want_n <= 2'b11;
    idle(8);
    `CHK(cpu_req.ext_req, 2'b00)
    // interrupt output: masked, unmasked, cleared
    wr(OFS_IRQ_MASK, 8'h00);
    idle(3);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 8'h07);
    idle(3);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 8'h07);
    idle(3);
    `CHK(irq, 1'b0)
    // a low clock enable drops a write
    ce <= 1'b0;
    wr(OFS_PENDING, 8'h5A);
    ce <= 1'b1;
    rd(OFS_PENDING, q);
    `CHK(q, 8'h00)
    // reset in mid-run returns flags and requests to idle
    wr(OFS_PENDING, 8'h42);
    idle(1);
    `CHK(cpu_req.key_req, 1'b1)
    rst <= 1'b1;
    idle(2);
    `CHK(cpu_req, 4'h0)
    `CHK(irq, 1'b0)
    rst <= 1'b0;
    rd(OFS_PENDING, q);
    `CHK(q, RST_BYTE)
    summarize();
  end
endmodule
